// file: common/tsio_pkg.sv
// ======================================================================
// shared constants for the timed serializing io port
package tsio_pkg;

    // ==================================================================
    // data path
    localparam int TSIO_WORD_W = 32;
    localparam int TSIO_CNT_W = 16;
    localparam int TSIO_FIFO_DEPTH = 8;
    localparam int TSIO_SLICE_W = 6;
    localparam int TSIO_PIN_W_DEF = 4;

    // ==================================================================
    // clock blocks
    localparam int TSIO_NUM_CLKBLK = 6;
    localparam int TSIO_CLKSEL_W = 3;
    localparam int TSIO_DIV_W = 8;
    localparam logic [TSIO_CLKSEL_W-1:0] TSIO_CLKSEL_RST = 3'h0;
    localparam logic [TSIO_CLKSEL_W-1:0] TSIO_CLKSEL_LAST = 3'h5;

    // ==================================================================
    // counter reset value and step
    localparam logic [TSIO_CNT_W-1:0] TSIO_CNT_RST = 16'h0000;
    localparam logic [TSIO_CNT_W-1:0] TSIO_CNT_STEP = 16'h0001;

    // ==================================================================
    // input condition modes
    typedef enum logic [1:0] {
        TSIO_COND_NONE = 2'h0,
        TSIO_COND_EQ = 2'h1,
        TSIO_COND_NEQ = 2'h2
    } tsio_cond_e;

    // ==================================================================
    // sequencer states
    typedef enum logic [1:0] {
        TSIO_ST_IDLE = 2'b01,
        TSIO_ST_BUSY = 2'b10
    } tsio_state_e;

endpackage

// file: common/tsio_stream_if.sv
`timescale 1ns/1ps
// ======================================================================
// word stream into and out of the transfer fifo
interface tsio_stream_if #(parameter int WIDTH = 32);
    logic wrValid;
    logic wrReady;
    logic [WIDTH-1:0] wrData;
    logic rdValid;
    logic rdReady;
    logic [WIDTH-1:0] rdData;

    modport fifo (input wrValid, input wrData, output wrReady,
                  output rdValid, output rdData, input rdReady);
    modport user (output wrValid, output wrData, input wrReady,
                  input rdValid, input rdData, output rdReady);
endinterface

// file: verilog/tsio_fifo.sv
`timescale 1ns/1ps
// ======================================================================
// transfer fifo with honest full and empty
module tsio_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    tsio_stream_if.fifo s
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr_reg;
    logic [AW:0] rdPtr_reg;

    wire full = (wrPtr_reg[AW] != rdPtr_reg[AW]) &&
                (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]);
    wire empty = (wrPtr_reg == rdPtr_reg);
    wire doWrite = s.wrValid && !full;
    wire doRead = s.rdReady && !empty;

    assign s.wrReady = !full;
    assign s.rdValid = !empty;
    assign s.rdData = mem[rdPtr_reg[AW-1:0]];

    always_ff @(posedge sys_clk) begin
        if (doWrite) begin
            mem[wrPtr_reg[AW-1:0]] <= s.wrData;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
        end else begin
            if (doWrite) wrPtr_reg <= wrPtr_reg + 1'b1;
            if (doRead) rdPtr_reg <= rdPtr_reg + 1'b1;
        end
    end
endmodule // tsio_fifo

// file: verilog/tsio_clkgen.sv
`timescale 1ns/1ps
// ======================================================================
// six clock blocks, each a one-cycle tick enable
module tsio_clkgen import tsio_pkg::*; #(
    parameter int NUM_BLK = TSIO_NUM_CLKBLK,
    parameter int DIV_W = TSIO_DIV_W
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic extClkPin,
    input wire logic [NUM_BLK-1:0] srcIsPin,
    input wire logic [NUM_BLK*DIV_W-1:0] divVal,
    output logic [NUM_BLK-1:0] blkTick
);
    logic extPrev_reg;
    wire extRise = extClkPin && !extPrev_reg;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) extPrev_reg <= 1'b0;
        else extPrev_reg <= extClkPin;
    end

    genvar g;
    generate
        for (g = 0; g < NUM_BLK; g++) begin : gBlk
            if (g == 0) begin : gRef
                // reference block ticks on every system cycle
                assign blkTick[g] = 1'b1;
            end else begin : gProg
                logic [DIV_W-1:0] divCnt_reg;
                // external 1-bit pin source or reference source
                wire srcEvt = srcIsPin[g] ? extRise : 1'b1;
                wire divHit = srcEvt &&
                    (divCnt_reg == divVal[g*DIV_W +: DIV_W]);
                assign blkTick[g] = divHit;
                always_ff @(posedge sys_clk or posedge sys_rst) begin
                    if (sys_rst) divCnt_reg <= '0;
                    else if (divHit) divCnt_reg <= '0;
                    else if (srcEvt) divCnt_reg <= divCnt_reg + 1'b1;
                end
            end
        end
    endgenerate
endmodule // tsio_clkgen

// file: verilog/tsio_port.sv
`timescale 1ns/1ps
// ======================================================================
module tsio_port import tsio_pkg::*; #(
    parameter int PIN_W = TSIO_PIN_W_DEF,
    parameter int DEPTH = TSIO_FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic cfgLoad,
    input wire logic cfgPortEn,
    input wire logic cfgDirOut,
    input wire logic cfgOpenDrain,
    input wire logic [TSIO_CLKSEL_W-1:0] cfgClkSel,
    input wire logic cfgStrobeEn,
    input wire logic [1:0] cfgCondMode,
    input wire logic [PIN_W-1:0] cfgCondValue,
    input wire logic [TSIO_NUM_CLKBLK-1:0] clkSrcIsPin,
    input wire logic [TSIO_NUM_CLKBLK*TSIO_DIV_W-1:0] clkDivVal,
    input wire logic extClkPin,
    input wire logic linkEnable,
    input wire logic [PIN_W-1:0] narrowClaim,
    input wire logic coreWrValid,
    input wire logic [TSIO_WORD_W-1:0] coreWrData,
    output logic coreWrReady,
    output logic coreRdValid,
    output logic [TSIO_WORD_W-1:0] coreRdData,
    input wire logic coreRdReady,
    input wire logic coreTimeValid,
    input wire logic [TSIO_CNT_W-1:0] coreTimeCount,
    output logic timeArmed,
    output logic [TSIO_CNT_W-1:0] portCount,
    output logic [TSIO_CNT_W-1:0] timestamp,
    input wire logic [PIN_W-1:0] pinIn,
    output logic [PIN_W-1:0] pinOut,
    output logic [PIN_W-1:0] pinOe,
    input wire logic readyIn,
    output logic outputSideStrobe
);
    // ==================================================================
    // derived sizes
    localparam int SLICES = TSIO_WORD_W / PIN_W;
    localparam logic [TSIO_SLICE_W-1:0] LAST_SLICE =
        TSIO_SLICE_W'(SLICES - 1);
    localparam logic [TSIO_SLICE_W-1:0] FIRST_NEXT = 6'h01;
    // only 1, 4, 8, 16 and 32 pins are enabled; others, 2 included, stay dark
    localparam bit WIDTH_OK = (PIN_W == 1) || (PIN_W == 4) ||
        (PIN_W == 8) || (PIN_W == 16) || (PIN_W == 32);

    // ==================================================================
    // configuration registers
    logic portEn_reg;
    logic dirOut_reg;
    logic openDrain_reg;
    logic [TSIO_CLKSEL_W-1:0] clkSel_reg;
    logic strobeEn_reg;
    tsio_cond_e condMode_reg;
    logic [PIN_W-1:0] condValue_reg;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            portEn_reg <= 1'b0;
            dirOut_reg <= 1'b0;
            openDrain_reg <= 1'b0;
            clkSel_reg <= TSIO_CLKSEL_RST;
            strobeEn_reg <= 1'b0;
            condMode_reg <= TSIO_COND_NONE;
            condValue_reg <= '0;
        end else if (cfgLoad) begin
            portEn_reg <= cfgPortEn;
            dirOut_reg <= cfgDirOut;
            openDrain_reg <= cfgOpenDrain;
            clkSel_reg <= cfgClkSel;
            strobeEn_reg <= cfgStrobeEn;
            condMode_reg <= tsio_cond_e'(cfgCondMode);
            condValue_reg <= cfgCondValue;
        end
    end

    // ==================================================================
    // clock blocks and port tick
    logic [TSIO_NUM_CLKBLK-1:0] blkTick;

    tsio_clkgen #(
        .NUM_BLK(TSIO_NUM_CLKBLK),
        .DIV_W(TSIO_DIV_W)
    ) uClk (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .extClkPin(extClkPin),
        .srcIsPin(clkSrcIsPin),
        .divVal(clkDivVal),
        .blkTick(blkTick)
    );

    // unused selector codes read a zero tick, never past the vector
    wire [2**TSIO_CLKSEL_W-1:0] tickAll =
        (2**TSIO_CLKSEL_W)'(blkTick);
    wire selValid = (clkSel_reg <= TSIO_CLKSEL_LAST);
    wire portTick = selValid && tickAll[clkSel_reg];

    // ==================================================================
    // port counter
    logic [TSIO_CNT_W-1:0] portCnt_reg;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) portCnt_reg <= TSIO_CNT_RST;
        else if (portTick) begin
            portCnt_reg <= portCnt_reg + TSIO_CNT_STEP;
        end
    end

    assign portCount = portCnt_reg;

    // ==================================================================
    // transfer fifo
    tsio_stream_if #(.WIDTH(TSIO_WORD_W)) fs ();

    tsio_fifo #(
        .WIDTH(TSIO_WORD_W),
        .DEPTH(DEPTH)
    ) uFifo (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .s(fs.fifo)
    );

    // ==================================================================
    // pin view and gating
    wire portLive = portEn_reg && !linkEnable && WIDTH_OK;
    wire [PIN_W-1:0] pinView = pinIn & ~narrowClaim;
    wire driveOn = portLive && dirOut_reg;
    wire sampleOn = portLive && !dirOut_reg;

    // ==================================================================
    // timed transfer request
    logic timeArmed_reg;
    logic [TSIO_CNT_W-1:0] timeCount_reg;
    wire timeOk = !timeArmed_reg || (portCnt_reg == timeCount_reg);

    // ==================================================================
    // input condition and strobe
    logic condMatch;
    always_comb begin
        case (condMode_reg)
            TSIO_COND_NONE: condMatch = 1'b1;
            TSIO_COND_EQ: condMatch = (pinView == condValue_reg);
            TSIO_COND_NEQ: condMatch = (pinView != condValue_reg);
            default: condMatch = 1'b1;
        endcase
    end

    wire strobeOk = !strobeEn_reg || readyIn;

    // ==================================================================
    // sequencer
    tsio_state_e state_reg;
    tsio_state_e state_next;
    logic [TSIO_WORD_W-1:0] shift_reg;
    logic [TSIO_SLICE_W-1:0] slice_reg;
    logic [PIN_W-1:0] pinVal_reg;
    logic [TSIO_CNT_W-1:0] stamp_reg;
    logic strobe_reg;
    logic inPush_reg;

    wire isIdle = (state_reg == TSIO_ST_IDLE);
    wire isBusy = (state_reg == TSIO_ST_BUSY);
    wire lastSlice = (slice_reg == LAST_SLICE);
    wire outStart = portTick && driveOn && isIdle && fs.rdValid && timeOk;
    wire inStart = portTick && sampleOn && isIdle && fs.wrReady &&
                   timeOk && condMatch && strobeOk;
    wire outStep = portTick && driveOn && isBusy;
    wire inStep = portTick && sampleOn && isBusy && strobeOk;
    wire wordStart = outStart || inStart;
    wire stepAny = outStep || inStep;
    wire singleSlice = (SLICES == 1);
    // new slice enters at the top; holds for every width up to the word
    wire [TSIO_WORD_W+PIN_W-1:0] inWide = {pinView, shift_reg};
    wire [TSIO_WORD_W-1:0] inShifted =
        inWide[TSIO_WORD_W+PIN_W-1:PIN_W];

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            TSIO_ST_IDLE: begin
                if (wordStart && !singleSlice) state_next = TSIO_ST_BUSY;
            end
            TSIO_ST_BUSY: begin
                if (!portLive) state_next = TSIO_ST_IDLE;
                else if (stepAny && lastSlice) state_next = TSIO_ST_IDLE;
            end
            default: state_next = TSIO_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) state_reg <= TSIO_ST_IDLE;
        else state_reg <= state_next;
    end

    // shift register: slices leave or enter low end first
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_reg <= '0;
            slice_reg <= '0;
        end else if (outStart) begin
            shift_reg <= fs.rdData >> PIN_W;
            slice_reg <= FIRST_NEXT;
        end else if (inStart || inStep) begin
            shift_reg <= inShifted;
            slice_reg <= inStart ? FIRST_NEXT : slice_reg + 1'b1;
        end else if (outStep) begin
            shift_reg <= shift_reg >> PIN_W;
            slice_reg <= slice_reg + 1'b1;
        end
    end

    // pin value register
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) pinVal_reg <= '0;
        else if (outStart) pinVal_reg <= fs.rdData[PIN_W-1:0];
        else if (outStep) pinVal_reg <= shift_reg[PIN_W-1:0];
    end

    // timestamp taken at each word transfer on the pins
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) stamp_reg <= TSIO_CNT_RST;
        else if (wordStart) stamp_reg <= portCnt_reg;
    end

    // output strobe stands for the tick period of each driven slice
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) strobe_reg <= 1'b0;
        else if (!driveOn) strobe_reg <= 1'b0;
        else if (portTick) strobe_reg <= outStart || outStep;
    end

    // completed input word goes to the fifo one cycle later
    wire inDone = (inStart && singleSlice) || (inStep && lastSlice);
    logic [TSIO_WORD_W-1:0] inWord_reg;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            inPush_reg <= 1'b0;
            inWord_reg <= '0;
        end else begin
            inPush_reg <= inDone;
            if (inDone) inWord_reg <= inShifted;
        end
    end

    // timed request: a new arm wins over the clear by a start
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            timeArmed_reg <= 1'b0;
            timeCount_reg <= TSIO_CNT_RST;
        end else if (coreTimeValid) begin
            timeArmed_reg <= 1'b1;
            timeCount_reg <= coreTimeCount;
        end else if (wordStart) begin
            timeArmed_reg <= 1'b0;
        end
    end

    assign timeArmed = timeArmed_reg;
    assign timestamp = stamp_reg;

    // ==================================================================
    // fifo steering by direction
    assign fs.wrValid = dirOut_reg ? coreWrValid : inPush_reg;
    assign fs.wrData = dirOut_reg ? coreWrData : inWord_reg;
    assign fs.rdReady = dirOut_reg ? outStart : coreRdReady;

    // single-cycle core handshakes
    assign coreWrReady = dirOut_reg && fs.wrReady;
    assign coreRdValid = !dirOut_reg && fs.rdValid;
    assign coreRdData = fs.rdData;

    // ==================================================================
    // pin drivers
    logic [PIN_W-1:0] pinOut_reg;
    logic [PIN_W-1:0] pinOe_reg;
    logic [PIN_W-1:0] oeNext;
    wire [PIN_W-1:0] outNext = openDrain_reg ? '0 : pinVal_reg;

    genvar b;
    generate
        for (b = 0; b < PIN_W; b++) begin : gPin
            // claimed pins released, the rest stay with this port
            assign oeNext[b] = driveOn && !narrowClaim[b] &&
                (!openDrain_reg || !pinVal_reg[b]);
        end
    endgenerate

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pinOut_reg <= '0;
            pinOe_reg <= '0;
        end else begin
            pinOut_reg <= outNext;
            pinOe_reg <= oeNext;
        end
    end

    assign pinOut = pinOut_reg;
    assign pinOe = pinOe_reg;
    assign outputSideStrobe = strobe_reg;

endmodule // tsio_port

// file: bench/tsio_port_chk.sv
`timescale 1ns/1ps
// ====================
// port checker
module tsio_port_chk import tsio_pkg::*; #(
    parameter int PIN_W = TSIO_PIN_W_DEF
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic cfgLoad,
    input wire logic cfgDirOut,
    input wire logic cfgOpenDrain,
    input wire logic [TSIO_CLKSEL_W-1:0] cfgClkSel,
    input wire logic linkEnable,
    input wire logic [PIN_W-1:0] narrowClaim,
    input wire logic coreWrReady,
    input wire logic coreTimeValid,
    input wire logic [TSIO_CNT_W-1:0] coreTimeCount,
    input wire logic timeArmed,
    input wire logic [TSIO_CNT_W-1:0] portCount,
    input wire logic [TSIO_CNT_W-1:0] timestamp,
    input wire logic [PIN_W-1:0] pinOut,
    input wire logic [PIN_W-1:0] pinOe
);
    logic dir_reg;
    logic od_reg;
    logic [TSIO_CLKSEL_W-1:0] sel_reg;
    logic [TSIO_CNT_W-1:0] arm_reg;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // ====================
    // mirror of the latched config and armed count
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dir_reg <= 1'b0;
            od_reg <= 1'b0;
            sel_reg <= TSIO_CLKSEL_RST;
            arm_reg <= TSIO_CNT_RST;
        end else begin
            if (cfgLoad) begin
                dir_reg <= cfgDirOut;
                od_reg <= cfgOpenDrain;
                sel_reg <= cfgClkSel;
            end
            if (coreTimeValid) begin
                arm_reg <= coreTimeCount;
            end
        end
    end

    // ====================
    // assertions
    chk_count_step: assert property (
        sel_reg == 3'h0 && $past(sel_reg) == 3'h0 && !$past(sys_rst)
        |-> portCount == $past(portCount) + TSIO_CNT_STEP)
        else $error("counter missed a reference tick");
    chk_count_frozen: assert property (
        sel_reg > TSIO_CLKSEL_LAST && $past(sel_reg) > TSIO_CLKSEL_LAST
        |-> $stable(portCount))
        else $error("counter moved without a clock block");
    chk_stamp_time: assert property (
        $fell(timeArmed) |-> timestamp == arm_reg)
        else $error("timed start off the armed count");
    chk_link_release: assert property (
        linkEnable && $past(linkEnable) |-> pinOe == '0)
        else $error("pins driven while link owns them");
    chk_claim_release: assert property (
        (narrowClaim & $past(narrowClaim) & pinOe) == '0)
        else $error("claimed pin still driven");
    chk_input_nodrive: assert property (
        !dir_reg && !$past(dir_reg) |-> pinOe == '0)
        else $error("input port drives a pin");
    chk_drain_low: assert property (
        od_reg && $past(od_reg) |-> (pinOut & pinOe) == '0)
        else $error("open drain drove a high");
    chk_write_refused: assert property (
        !dir_reg |-> !coreWrReady)
        else $error("input port took a core word");
endmodule // tsio_port_chk

bind tsio_port tsio_port_chk #(.PIN_W(PIN_W)) i_tsio_port_chk (
    .sys_clk, .sys_rst, .cfgLoad, .cfgDirOut, .cfgOpenDrain, .cfgClkSel,
    .linkEnable, .narrowClaim, .coreWrReady, .coreTimeValid,
    .coreTimeCount, .timeArmed, .portCount, .timestamp, .pinOut, .pinOe);

// file: bench/tsio_ext_model.sv
`timescale 1ns/1ps
// ====================
// outside hardware on the pins
module tsio_ext_model import tsio_pkg::*; #(
    parameter int PIN_W = TSIO_PIN_W_DEF
) (
    input wire logic sys_clk,
    input wire logic [PIN_W-1:0] pinOut,
    input wire logic [PIN_W-1:0] pinOe,
    output logic [PIN_W-1:0] pinIn,
    output logic readyIn,
    output logic extClkPin
);
    logic [PIN_W-1:0] pinDrive = '0;

    initial begin
        readyIn = 1'b0;
        extClkPin = 1'b0;
    end

    // a pin the port drives shows the port's level
    assign pinIn = (pinOut & pinOe) | (pinDrive & ~pinOe);

    // junk slices with strobe, then one word low slice first
    task automatic present(input logic [PIN_W-1:0] junk, input int nj,
            input logic [TSIO_WORD_W-1:0] w);
        for (int i = 0; i < nj; i++) begin
            @(negedge sys_clk);
            pinDrive = junk;
            readyIn = 1'b1;
        end
        for (int k = 0; k < TSIO_WORD_W / PIN_W; k++) begin
            @(negedge sys_clk);
            pinDrive = w[k*PIN_W +: PIN_W];
            readyIn = 1'b1;
        end
        @(negedge sys_clk);
        readyIn = 1'b0;
        pinDrive = ~pinDrive;
    endtask

    // application clock, idle low between bursts
    task automatic pulses(input int n);
        repeat (n) begin
            repeat (2) @(negedge sys_clk);
            extClkPin = 1'b1;
            repeat (2) @(negedge sys_clk);
            extClkPin = 1'b0;
        end
    endtask
endmodule // tsio_ext_model

// file: bench/testbench.sv
`timescale 1ns/1ps
// ====================
// bench for the timed port, four pins
module testbench import tsio_pkg::*;;
    localparam int PW = 4;
    localparam int NSL = TSIO_WORD_W / PW;
    logic sys_clk = 1'b0, sys_rst = 1'b1, cfgLoad = 1'b0, cfgPortEn = 1'b1;
    logic cfgDirOut = 1'b0, cfgOpenDrain = 1'b0, cfgStrobeEn = 1'b0;
    logic linkEnable = 1'b0, coreWrValid = 1'b0, coreRdReady = 1'b0;
    logic coreTimeValid = 1'b0, extClkPin, readyIn;
    logic coreWrReady, coreRdValid, timeArmed, outputSideStrobe;
    logic [TSIO_CLKSEL_W-1:0] cfgClkSel = 3'h0;
    logic [1:0] cfgCondMode = 2'h0;
    logic [PW-1:0] cfgCondValue = 4'h0, narrowClaim = 4'h0;
    logic [PW-1:0] pinIn, pinOut, pinOe;
    logic [TSIO_NUM_CLKBLK-1:0] clkSrcIsPin = 6'h3e;
    logic [TSIO_NUM_CLKBLK*TSIO_DIV_W-1:0] clkDivVal = 48'h0403_0201_0000;
    logic [TSIO_WORD_W-1:0] coreWrData = 32'h0, coreRdData;
    logic [TSIO_CNT_W-1:0] coreTimeCount = 16'h0, portCount, timestamp;
    int failures = 0, total_checks = 0;

    tsio_port #(.PIN_W(PW)) i_tsio_port (
        .sys_clk, .sys_rst, .cfgLoad, .cfgPortEn, .cfgDirOut, .cfgOpenDrain,
        .cfgClkSel, .cfgStrobeEn, .cfgCondMode, .cfgCondValue, .clkSrcIsPin,
        .clkDivVal, .extClkPin, .linkEnable, .narrowClaim, .coreWrValid,
        .coreWrData, .coreWrReady, .coreRdValid, .coreRdData, .coreRdReady,
        .coreTimeValid, .coreTimeCount, .timeArmed, .portCount, .timestamp,
        .pinIn, .pinOut, .pinOe, .readyIn, .outputSideStrobe);
    tsio_ext_model #(.PIN_W(PW)) i_tsio_ext_model (
        .sys_clk, .pinOut, .pinOe, .pinIn, .readyIn, .extClkPin);

    // ====================
    // shared tasks
    task automatic check(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic cfg(input logic dir, od, input logic [2:0] sel);
        @(negedge sys_clk);
        cfgDirOut = dir;
        cfgOpenDrain = od;
        cfgClkSel = sel;
        cfgLoad = 1'b1;
        @(negedge sys_clk);
        cfgLoad = 1'b0;
    endtask

    task automatic wr(input logic [31:0] w);
        int n = 0;
        @(negedge sys_clk);
        coreWrValid = 1'b1;
        coreWrData = w;
        while (coreWrReady !== 1'b1 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        check("write taken", 1'b1, coreWrReady);
        @(negedge sys_clk);
        coreWrValid = 1'b0;
    endtask

    task automatic wait_strobe();
        int n = 0;
        while (outputSideStrobe !== 1'b1 && n < 80) begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    task automatic outw(input logic [31:0] w, input logic od,
            input logic [PW-1:0] claim);
        logic [PW-1:0] s, oe;
        wait_strobe();
        check("strobe", 1'b1, outputSideStrobe);
        for (int k = 0; k < NSL; k++) begin
            @(negedge sys_clk);
            s = w[k*PW +: PW];
            oe = (od ? ~s : 4'hf) & ~claim;
            check("pin enable", oe, pinOe);
            check("pin level", s & oe & {PW{!od}}, pinOut & oe);
        end
    endtask

    task automatic inw(input tsio_cond_e md, input logic [PW-1:0] v,
            input logic [PW-1:0] junk, input int nj, input logic [31:0] w,
            input logic sen);
        int n = 0;
        cfgStrobeEn = sen;
        cfgCondMode = md;
        cfgCondValue = v;
        cfg(1'b0, 1'b0, 3'h0);
        i_tsio_ext_model.present(junk, nj, w);
        while (coreRdValid !== 1'b1 && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        check("word in", w, coreRdData);
        coreRdReady = 1'b1;
        @(negedge sys_clk);
        coreRdReady = 1'b0;
        check("in fifo empty", 1'b0, coreRdValid);
    endtask

    // ====================
    // scenarios
    task automatic sc_reset();
        logic [15:0] c;
        repeat (2) @(negedge sys_clk);
        check("count in reset", 16'h0, portCount);
        check("oe in reset", 4'h0, pinOe);
        repeat (4) @(negedge sys_clk);
        sys_rst = 1'b0;
        @(negedge sys_clk);
        c = portCount;
        repeat (5) @(negedge sys_clk);
        check("count step", c + 16'h5, portCount);
    endtask

    task automatic sc_drive();
        cfg(1'b1, 1'b0, 3'h0);
        wr(32'h8765_4321);
        outw(32'h8765_4321, 1'b0, 4'h0);
        cfg(1'b1, 1'b1, 3'h0);
        wr(32'h0f5a_c396);
        outw(32'h0f5a_c396, 1'b1, 4'h0);
        cfg(1'b1, 1'b0, 3'h0);
        narrowClaim = 4'h3;
        wr(32'hc396_0f5a);
        outw(32'hc396_0f5a, 1'b0, 4'h3);
        narrowClaim = 4'h0;
    endtask

    task automatic sc_link();
        wr(32'h1234_5678);
        wait_strobe();
        linkEnable = 1'b1;
        repeat (4) begin
            @(negedge sys_clk);
            check("oe under link", 4'h0, pinOe);
        end
        linkEnable = 1'b0;
        repeat (60) @(negedge sys_clk);
    endtask

    task automatic sc_timed();
        logic [15:0] t;
        t = portCount + 16'h0028;
        coreTimeValid = 1'b1;
        coreTimeCount = t;
        @(negedge sys_clk);
        coreTimeValid = 1'b0;
        wr(32'h55aa_33cc);
        repeat (20) @(negedge sys_clk);
        check("held by time", 1'b1, timeArmed);
        check("no early slice", 1'b0, outputSideStrobe);
        outw(32'h55aa_33cc, 1'b0, 4'h0);
        check("stamp", t, timestamp);
        check("armed cleared", 1'b0, timeArmed);
    endtask

    task automatic sc_fifo();
        int n = 0;
        cfg(1'b1, 1'b0, 3'h6);
        for (int i = 0; i < 12; i++) begin
            @(negedge sys_clk);
            coreWrValid = coreWrReady;
            coreWrData = 32'(i + 1);
            if (coreWrReady === 1'b1) begin
                n++;
            end
        end
        @(negedge sys_clk);
        coreWrValid = 1'b0;
        check("fifo depth", TSIO_FIFO_DEPTH, n);
        check("full refuses", 1'b0, coreWrReady);
        cfg(1'b1, 1'b0, 3'h0);
        repeat (120) @(negedge sys_clk);
        check("drained", 1'b1, coreWrReady);
        check("strobe idle", 1'b0, outputSideStrobe);
    endtask

    task automatic sc_input();
        inw(TSIO_COND_EQ, 4'h9, 4'h3, 3, 32'h2468_ace9, 1'b1);
        inw(TSIO_COND_NEQ, 4'h3, 4'h3, 3, 32'h1357_9bd5, 1'b1);
        inw(TSIO_COND_NONE, 4'h0, 4'h0, 0, 32'hfedc_ba98, 1'b1);
        inw(TSIO_COND_EQ, 4'h7, 4'h3, 2, 32'h0123_4567, 1'b0);
    endtask

    task automatic sc_clocks();
        logic [15:0] c;
        for (int g = 1; g < TSIO_NUM_CLKBLK; g++) begin
            cfg(1'b0, 1'b0, g[2:0]);
            c = portCount;
            i_tsio_ext_model.pulses(60);
            repeat (4) @(negedge sys_clk);
            check("pin ticks", c + 16'(60 / g), portCount);
        end
    endtask

    // ====================
    // clock, watchdog, sequence
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    // roughly five times the expected run
    initial begin
        #200000;
        failures++;
        end_of_test();
    end

    initial begin
        sc_reset();
        sc_drive();
        sc_link();
        sc_timed();
        sc_fifo();
        sc_input();
        sc_clocks();
        end_of_test();
    end
endmodule // testbench
